//--- rtl/aacl_pkg.sv
// Contract
// - A cycle-time code of zero in setup bits 7:5 turns automatic conversion off.
// - After reset the cycle-time code reads zero so no automatic conversion runs.
// - Writing a non-zero cycle-time code starts automatic conversions at once.
// - Codes 1 to 7 space conversions by the conversion time times 32 up to 2048.
// - With alert hold clear an alert clears once the value is back inside by hysteresis.
// - With alert hold set an alert stays until the host writes a one to its status flag.
// - Setup bit 3 gates the alert into result bit 15 and otherwise leaves it zero.
// - Setup bit 2 enables the alert pin and otherwise the pin is released.
// - Setup bit 0 picks the alert level, zero for active low and one for active high.
// - Setup bit 1 and threshold bits 15:12 always read zero and are written as zero.
// - A result below the 12-bit lower threshold raises the under-range alert.
// - A result above the 12-bit upper threshold raises the over-range alert.
// - Over-range clears below upper minus hysteresis, under-range above lower plus it.
// - With mirroring on, result bit 15 is high when either status flag is set.
// package of register map, field positions, reset values and timing counts
// assumes a 200 MHz core clock and a two-wire serial host
package aacl_pkg;
   localparam logic [2:0]  PTR_RESULT = 3'h0;
   localparam logic [2:0]  PTR_STATUS = 3'h1;
   localparam logic [2:0]  PTR_SETUP  = 3'h2;
   localparam logic [2:0]  PTR_UNDER  = 3'h3;
   localparam logic [2:0]  PTR_OVER   = 3'h4;
   localparam logic [2:0]  PTR_HYST   = 3'h5;
   localparam logic [7:0]  SETUP_RST  = 8'h00;
   localparam logic [15:0] UNDER_RST  = 16'h0000;
   localparam logic [15:0] OVER_RST   = 16'h0fff;
   localparam logic [15:0] HYST_RST   = 16'h0000;
   localparam logic [7:0]  SETUP_WMASK = 8'hfd;    // reserved bit 1 forced low
   localparam logic [15:0] LIMIT_WMASK = 16'h0fff; // reserved bits 15:12 forced low
   localparam int CYC_HI       = 7;
   localparam int CYC_LO       = 5;
   localparam int HOLD_BIT     = 4;
   localparam int FLAG_EN_BIT  = 3;
   localparam int PIN_EN_BIT   = 2;
   localparam int POL_BIT      = 0;
   localparam int ST_OVER_BIT  = 1;
   localparam int ST_UNDER_BIT = 0;
   localparam int LIMIT_W      = 12;
   localparam logic [6:0] DEV_ADDR_RST = 7'h50;   // arbitrary bus address
   localparam int CLK_PERIOD_NS             = 5;
   localparam int SINGLE_CONVERSION_TIME_NS = 1000;
   localparam int SINGLE_CONVERSION_CYC     =
      (SINGLE_CONVERSION_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] INTERVAL_SHIFT0 = 5'h4; // code 1 gives times 32

   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} aacl_st_e;

   // spacing of automatic conversions in core cycles for a cycle-time code
   function automatic logic [31:0] aacl_interval(input logic [2:0]  code,
                                                 input logic [31:0] base);
      return base << (5'(code) + INTERVAL_SHIFT0);
   endfunction : aacl_interval
endpackage : aacl_pkg

//--- rtl/aacl_link_if.sv
// interface carrying conversion requests and results between the two clock domains
// assumes toggles are synchronised by the receiving side
`timescale 1ns/100ps
interface aacl_link_if;
   logic        req_tgl;   // flips once per conversion request
   logic        done_tgl;  // flips once per finished conversion
   logic [11:0] data;      // result, loaded on the same edge that flips done_tgl
   modport core (output req_tgl, input done_tgl, input data);
   modport link (input req_tgl, output done_tgl, output data);
endinterface : aacl_link_if

//--- rtl/aacl_conv_link.sv
// converter-facing logic on the conversion clock
// assumes the converter answers each start with one done pulse on the same clock
`timescale 1ns/100ps
module aacl_conv_link import aacl_pkg::*; (
   input  wire logic        i_conv_clk,   // conversion clock
   input  wire logic        i_rst_n,      // core reset, resynchronised here
   aacl_link_if.link        lnk,          // crossing to the core
   input  wire logic        i_conv_done,  // converter finished
   input  wire logic [11:0] i_conv_data,  // converter result
   output logic             o_conv_start  // start pulse to converter
);
   logic        rst_s1_ff, rst_s2_ff;
   logic        req_s1_ff, req_s2_ff, req_s3_ff;
   logic        busy_ff, done_ff;
   logic [11:0] data_ff;
   wire         req_edge = req_s2_ff ^ req_s3_ff;

   // reset synchroniser, the request is synchronised in the block below
   always_ff @(posedge i_conv_clk) begin
      rst_s1_ff <= i_rst_n;
      rst_s2_ff <= rst_s1_ff;
   end

   // start converter on each request, return result by toggle
   always_ff @(posedge i_conv_clk) begin
      if (!rst_s2_ff) begin
         req_s1_ff    <= 1'b0;
         req_s2_ff    <= 1'b0;
         req_s3_ff    <= 1'b0;
         busy_ff      <= 1'b0;
         done_ff      <= 1'b0;
         data_ff      <= 12'h000;
         o_conv_start <= 1'b0;
      end else begin
         req_s1_ff    <= lnk.req_tgl;
         req_s2_ff    <= req_s1_ff;
         req_s3_ff    <= req_s2_ff;
         o_conv_start <= req_edge;
         if (req_edge) begin
            busy_ff <= 1'b1;
         end else if (busy_ff && i_conv_done) begin
            busy_ff <= 1'b0;
            data_ff <= i_conv_data;
            done_ff <= ~done_ff;
         end
      end
   end
   assign lnk.done_tgl = done_ff;
   assign lnk.data     = data_ff;

   property p_start_on_req;
      @(posedge i_conv_clk) disable iff (!rst_s2_ff) req_edge |=> o_conv_start && busy_ff;
   endproperty
   a_start_on_req: assert property (p_start_on_req) else $error("no start pulse");
endmodule : aacl_conv_link

//--- rtl/aacl_top.sv
// alert, setup and threshold logic with a two-wire register slave
// assumes a pulled-up bus and a converter on its own clock
`timescale 1ns/100ps
module aacl_top import aacl_pkg::*; #(
   parameter logic [6:0] P_DEV_ADDR = DEV_ADDR_RST,
   parameter int         P_CONV_CYC = SINGLE_CONVERSION_CYC
)(
   input  wire logic        i_core_clk,   // core clock
   input  wire logic        i_rst_n,      // synchronous reset
   input  wire logic        i_conv_clk,   // converter clock
   input  wire logic        i_scl,        // serial clock pin
   input  wire logic        i_sda,        // serial data pin level
   output logic             o_sda_out,    // serial data drive value
   output logic             o_sda_oe_n,   // low while pulling data
   output logic             o_alert,      // alert pin value
   output logic             o_alert_oe_n, // low while alert driven
   input  wire logic        i_conv_done,  // converter finished
   input  wire logic [11:0] i_conv_data,  // converter result
   output logic             o_conv_start  // converter start pulse
);
   localparam int FIRE_MAX = 2;
   aacl_link_if lnk ();

   aacl_conv_link u_link (
      .i_conv_clk   (i_conv_clk),
      .i_rst_n      (i_rst_n),
      .lnk          (lnk),
      .i_conv_done  (i_conv_done),
      .i_conv_data  (i_conv_data),
      .o_conv_start (o_conv_start)
   );

   logic       scl_s1_ff, scl_s2_ff, scl_s3_ff, sda_s1_ff, sda_s2_ff, sda_s3_ff;
   logic       dn_s1_ff, dn_s2_ff, dn_s3_ff;
   aacl_st_e   st_ff, nxt_st;
   logic [3:0] bit_ff, nxt_bit;
   logic [7:0] sh_ff, nxt_sh, hi_ff;
   logic [1:0] idx_ff, nxt_idx;
   logic       drv_ff, nxt_drv, nack_ff, nxt_nack, rw_ff, rdlo_ff, nxt_rdlo;
   logic [2:0] ptr_ff;
   logic [7:0] setup_ff;
   logic [15:0] under_ff, over_ff, hyst_ff;
   logic [11:0] result_ff;
   logic       ovr_ff, und_ff, req_ff, busy_ff;
   logic [31:0] tmr_ff;

   // bus edge and condition decode
   wire scl_rise = scl_s2_ff & ~scl_s3_ff;
   wire scl_fall = ~scl_s2_ff & scl_s3_ff;
   wire start_c  = scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
   wire stop_c   = scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;
   wire byte_end = scl_fall && st_ff == ST_RX && bit_ff == 4'h8;
   wire addr_ok  = idx_ff != 2'h0 || sh_ff[7:1] == P_DEV_ADDR;
   wire wr_acc   = byte_end && addr_ok && !start_c && !stop_c;
   wire is8      = ptr_ff == PTR_STATUS || ptr_ff == PTR_SETUP;
   wire wr8      = wr_acc && idx_ff == 2'h2 && is8;
   wire wr16     = wr_acc && idx_ff == 2'h3 && !is8;
   wire [15:0] wdat = {hi_ff, sh_ff};
   wire wr_setup = wr8 && ptr_ff == PTR_SETUP;
   wire w1c_ovr  = wr8 && ptr_ff == PTR_STATUS && sh_ff[ST_OVER_BIT];
   wire w1c_und  = wr8 && ptr_ff == PTR_STATUS && sh_ff[ST_UNDER_BIT];

   // setup fields
   wire [2:0] cyc_code = setup_ff[CYC_HI:CYC_LO];
   wire hold   = setup_ff[HOLD_BIT];
   wire flg_en = setup_ff[FLAG_EN_BIT];
   wire pin_en = setup_ff[PIN_EN_BIT];
   wire pol    = setup_ff[POL_BIT];
   wire alert  = ovr_ff | und_ff;

   // read word and byte selection
   wire [15:0] res_word = {flg_en & alert, 3'h0, result_ff};
   wire [15:0] rd_word  = ptr_ff == PTR_RESULT ? res_word :
                          ptr_ff == PTR_STATUS ? {14'h0000, ovr_ff, und_ff} :
                          ptr_ff == PTR_SETUP  ? {8'h00, setup_ff} :
                          ptr_ff == PTR_UNDER  ? under_ff :
                          ptr_ff == PTR_OVER   ? over_ff :
                          ptr_ff == PTR_HYST   ? hyst_ff : 16'h0000;
   wire [7:0] tx_cur  = (is8 || rdlo_ff) ? rd_word[7:0] : rd_word[15:8];
   wire [7:0] tx_next = (is8 || !rdlo_ff) ? rd_word[7:0] : rd_word[15:8];

   // conversion pacing
   wire auto_on = cyc_code != 3'h0;
   wire fire    = auto_on && tmr_ff == 32'h0000_0000 && !busy_ff && !wr_setup;
   wire res_evt = dn_s2_ff ^ dn_s3_ff;
   wire [11:0] cval = lnk.data;

   // limit comparisons with hysteresis, 13 bits to catch wrap
   wire [12:0] hi_band  = {1'b0, over_ff[11:0]} - {1'b0, hyst_ff[11:0]};
   wire [12:0] lo_band  = {1'b0, under_ff[11:0]} + {1'b0, hyst_ff[11:0]};
   wire ovr_set  = res_evt && cval > over_ff[LIMIT_W-1:0];
   wire und_set  = res_evt && cval < under_ff[LIMIT_W-1:0];
   wire ovr_self = res_evt && !hold && !hi_band[12] && cval < hi_band[11:0];
   wire und_self = res_evt && !hold && {1'b0, cval} > lo_band;

   // bus slave next state
   always_comb begin
      nxt_st   = st_ff;
      nxt_bit  = bit_ff;
      nxt_sh   = sh_ff;
      nxt_idx  = idx_ff;
      nxt_drv  = drv_ff;
      nxt_nack = nack_ff;
      nxt_rdlo = rdlo_ff;
      if (start_c) begin
         nxt_st  = ST_RX;
         nxt_bit = 4'h0;
         nxt_idx = 2'h0;
         nxt_drv = 1'b0;
      end else if (stop_c) begin
         nxt_st  = ST_IDLE;
         nxt_drv = 1'b0;
      end else if (scl_rise) begin
         if (st_ff == ST_RX && bit_ff != 4'h8) begin
            nxt_sh  = {sh_ff[6:0], sda_s2_ff};
            nxt_bit = bit_ff + 4'h1;
         end
         if (st_ff == ST_TXACK) begin
            nxt_nack = sda_s2_ff;
         end
      end else if (scl_fall) begin
         unique case (st_ff)
            ST_IDLE: begin
               nxt_drv = 1'b0;
            end
            ST_RX: begin
               if (bit_ff == 4'h8) begin
                  nxt_st  = addr_ok ? ST_ACK : ST_IDLE;
                  nxt_drv = addr_ok;
               end
            end
            ST_ACK: begin
               nxt_bit = 4'h1;
               if (rw_ff) begin
                  nxt_st  = ST_TX;
                  nxt_sh  = tx_cur;
                  nxt_drv = ~tx_cur[7];
               end else begin
                  nxt_st  = ST_RX;
                  nxt_bit = 4'h0;
                  nxt_drv = 1'b0;
                  nxt_idx = idx_ff == 2'h3 ? 2'h3 : idx_ff + 2'h1;
               end
            end
            ST_TX: begin
               if (bit_ff == 4'h8) begin
                  nxt_st  = ST_TXACK;
                  nxt_drv = 1'b0;
               end else begin
                  nxt_drv = ~sh_ff[6];
                  nxt_sh  = {sh_ff[6:0], 1'b0};
                  nxt_bit = bit_ff + 4'h1;
               end
            end
            ST_TXACK: begin
               nxt_st   = nack_ff ? ST_IDLE : ST_TX;
               nxt_sh   = tx_next;
               nxt_drv  = ~nack_ff & ~tx_next[7];
               nxt_bit  = 4'h1;
               nxt_rdlo = ~rdlo_ff;
            end
         endcase
      end
   end

   // pin synchronisers
   always_ff @(posedge i_core_clk) begin
      scl_s1_ff <= i_scl;
      scl_s2_ff <= scl_s1_ff;
      scl_s3_ff <= scl_s2_ff;
      sda_s1_ff <= i_sda;
      sda_s2_ff <= sda_s1_ff;
      sda_s3_ff <= sda_s2_ff;
   end

   // bus slave state
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         st_ff   <= ST_IDLE;
         bit_ff  <= 4'h0;
         sh_ff   <= 8'h00;
         idx_ff  <= 2'h0;
         drv_ff  <= 1'b0;
         nack_ff <= 1'b0;
         rdlo_ff <= 1'b0;
      end else begin
         st_ff   <= nxt_st;
         bit_ff  <= nxt_bit;
         sh_ff   <= nxt_sh;
         idx_ff  <= nxt_idx;
         drv_ff  <= nxt_drv;
         nack_ff <= nxt_nack;
         rdlo_ff <= (wr_acc && idx_ff == 2'h0) ? 1'b0 : nxt_rdlo;
      end
   end

   // pointer and register writes
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         rw_ff    <= 1'b0;
         ptr_ff   <= PTR_RESULT;
         hi_ff    <= 8'h00;
         setup_ff <= SETUP_RST;
         under_ff <= UNDER_RST;
         over_ff  <= OVER_RST;
         hyst_ff  <= HYST_RST;
      end else if (wr_acc) begin
         if (idx_ff == 2'h0) rw_ff <= sh_ff[0];
         if (idx_ff == 2'h1) ptr_ff <= sh_ff[2:0];
         if (idx_ff == 2'h2) hi_ff <= sh_ff;
         if (wr_setup) setup_ff <= sh_ff & SETUP_WMASK;
         if (wr16 && ptr_ff == PTR_UNDER) under_ff <= wdat & LIMIT_WMASK;
         if (wr16 && ptr_ff == PTR_OVER) over_ff <= wdat & LIMIT_WMASK;
         if (wr16 && ptr_ff == PTR_HYST) hyst_ff <= wdat & LIMIT_WMASK;
      end
   end

   // conversion timer and request toggle
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         tmr_ff  <= 32'h0000_0000;
         req_ff  <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         if (wr_setup) tmr_ff <= 32'h0000_0000;
         else if (fire) tmr_ff <= aacl_interval(cyc_code, 32'(P_CONV_CYC)) - 32'h1;
         else if (auto_on && tmr_ff != 32'h0000_0000) tmr_ff <= tmr_ff - 32'h1;
         if (fire) req_ff <= ~req_ff;
         busy_ff <= fire | (busy_ff & ~res_evt);
      end
   end
   assign lnk.req_tgl = req_ff;

   // result capture and alert flags, a set beats a clear
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         dn_s1_ff  <= 1'b0;
         dn_s2_ff  <= 1'b0;
         dn_s3_ff  <= 1'b0;
         result_ff <= 12'h000;
         ovr_ff    <= 1'b0;
         und_ff    <= 1'b0;
      end else begin
         dn_s1_ff <= lnk.done_tgl;
         dn_s2_ff <= dn_s1_ff;
         dn_s3_ff <= dn_s2_ff;
         if (res_evt) result_ff <= cval;
         ovr_ff <= ovr_set | (ovr_ff & ~ovr_self & ~w1c_ovr);
         und_ff <= und_set | (und_ff & ~und_self & ~w1c_und);
      end
   end

   // pin outputs
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_sda_out    <= 1'b0;
         o_sda_oe_n   <= 1'b1;
         o_alert      <= 1'b1;
         o_alert_oe_n <= 1'b1;
      end else begin
         o_sda_out    <= 1'b0;
         o_sda_oe_n   <= ~drv_ff;
         o_alert      <= ~(alert ^ pol);
         o_alert_oe_n <= ~pin_en;
      end
   end

   sequence s_setup_on;
      wr_setup && sh_ff[CYC_HI:CYC_LO] != 3'h0 && !busy_ff;
   endsequence
   sequence s_fire_soon;
      ##[1:FIRE_MAX] fire;
   endsequence
   // a zero code in the previous cycle must leave the request toggle untouched
   property p_auto_off;
      @(posedge i_core_clk) disable iff (!i_rst_n)
         $past(cyc_code) == 3'h0 |-> $stable(lnk.req_tgl);
   endproperty
   a_auto_off: assert property (p_auto_off) else $error("conversion while off");
   property p_reset_off;
      @(posedge i_core_clk) disable iff (!i_rst_n) $rose(i_rst_n) |-> setup_ff == SETUP_RST;
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("setup not cleared");
   property p_start_now;
      @(posedge i_core_clk) disable iff (!i_rst_n) s_setup_on |-> s_fire_soon;
   endproperty
   a_start_now: assert property (p_start_now) else $error("no prompt start");
   property p_interval;
      @(posedge i_core_clk) disable iff (!i_rst_n)
         fire |=> tmr_ff == aacl_interval($past(cyc_code), 32'(P_CONV_CYC)) - 32'h1;
   endproperty
   a_interval: assert property (p_interval) else $error("bad interval");
   property p_self_clear;
      @(posedge i_core_clk) disable iff (!i_rst_n) ovr_self && !ovr_set |=> !ovr_ff;
   endproperty
   a_self_clear: assert property (p_self_clear) else $error("no self clear");
   property p_hold;
      @(posedge i_core_clk) disable iff (!i_rst_n) hold && ovr_ff && !w1c_ovr |=> ovr_ff;
   endproperty
   a_hold: assert property (p_hold) else $error("held alert dropped");
   // first bit shifted out of a result read carries the gated alert
   property p_mirror;
      @(posedge i_core_clk) disable iff (!i_rst_n)
         scl_fall && st_ff == ST_ACK && rw_ff && ptr_ff == PTR_RESULT
         |=> sh_ff[7] == $past(flg_en && alert);
   endproperty
   a_mirror: assert property (p_mirror) else $error("bad result alert bit");
   property p_pin_off;
      @(posedge i_core_clk) disable iff (!i_rst_n) !pin_en |=> o_alert_oe_n;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("alert driven while off");
   property p_level;
      @(posedge i_core_clk) disable iff (!i_rst_n) alert |=> o_alert == $past(pol);
   endproperty
   a_level: assert property (p_level) else $error("wrong alert level");
   property p_rsvd;
      @(posedge i_core_clk) disable iff (!i_rst_n)
         setup_ff[1] == 1'b0 && under_ff[15:12] == 4'h0 && over_ff[15:12] == 4'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_over;
      @(posedge i_core_clk) disable iff (!i_rst_n) ovr_set |=> ovr_ff;
   endproperty
   a_over: assert property (p_over) else $error("over-range missed");
endmodule : aacl_top

//--- testbench/aacl_conv_model.sv
// behavioural converter that answers each start pulse with one done pulse
// assumes start pulses arrive one converter clock wide
`timescale 1ns/100ps
module aacl_conv_model (
   input  wire logic        i_conv_clk, // converter clock
   input  wire logic        i_start,    // start pulse from the block
   input  wire logic [11:0] i_value,    // value to be converted
   output logic             o_done,     // one-cycle done pulse
   output logic [11:0]      o_data,     // result, scrambled outside done
   output int               o_count     // finished conversions
);
   logic [1:0] busy_ff;
   initial begin
      busy_ff = 2'h0;
      o_done  = 1'b0;
      o_data  = 12'h000;
      o_count = 0;
   end
   // two-cycle conversion; data is only valid with done, so flip it otherwise
   always @(posedge i_conv_clk) begin
      busy_ff <= {busy_ff[0], i_start};
      o_done  <= busy_ff[1];
      o_data  <= busy_ff[1] ? i_value : ~o_data;
      if (busy_ff[1]) o_count <= o_count + 1;
   end
endmodule : aacl_conv_model

//--- testbench/aacl_top_bench.sv
// self-checking bench: bit-level two-wire master tasks plus converter model
// assumes a pulled-up data wire and a converter on its own clock
`timescale 1ns/100ps
module aacl_top_bench import aacl_pkg::*;;
   localparam int P_CONV = 4;
   logic        core_clk = 1'b0; // core clock
   logic        conv_clk = 1'b0; // converter clock
   logic        rst_n = 1'b0;    // reset
   logic        scl_m = 1'b1;    // master clock level
   logic        sda_m = 1'b1;    // master data release
   logic [11:0] value = 12'h000; // analog value
   logic        sda_oe_n, sda_out, alert, alert_oe_n, conv_start, conv_done;
   logic [11:0] conv_data;
   logic [15:0] d;
   int          conv_count, c0;
   int          fail_count = 0;
   int          n_tests = 0;
   real         t0, ex;
   wire logic   sda = sda_m & (sda_oe_n | sda_out); // pulled-up wire

   aacl_top #(.P_CONV_CYC(P_CONV)) aacl_top_inst (.i_core_clk(core_clk), .i_rst_n(rst_n),
      .i_conv_clk(conv_clk), .i_scl(scl_m), .i_sda(sda), .o_sda_out(sda_out),
      .o_sda_oe_n(sda_oe_n), .o_alert(alert), .o_alert_oe_n(alert_oe_n),
      .i_conv_done(conv_done), .i_conv_data(conv_data), .o_conv_start(conv_start));
   aacl_conv_model aacl_conv_model_inst (.i_conv_clk(conv_clk), .i_start(conv_start),
      .i_value(value), .o_done(conv_done), .o_data(conv_data), .o_count(conv_count));

   // clocks, the converter one offset so the edges never line up
   always #2.5 core_clk = ~core_clk;
   initial begin
      #13.1;
      forever #40 conv_clk = ~conv_clk;
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic half();
      repeat (10) @(negedge core_clk);
   endtask : half
   task automatic put_bit(input logic b);
      sda_m = b;
      half();
      scl_m = 1'b1;
      half();
      scl_m = 1'b0;
   endtask : put_bit
   task automatic get_bit(output logic b);
      sda_m = 1'b1;
      half();
      scl_m = 1'b1;
      half();
      b = sda;
      scl_m = 1'b0;
   endtask : get_bit
   task automatic put_byte(input logic [7:0] v);
      logic a;
      for (int i = 7; i >= 0; i--) put_bit(v[i]);
      get_bit(a);
      check("ack", 16'(a), 16'h0000);
   endtask : put_byte
   task automatic get_byte(output logic [7:0] v, input logic nack);
      for (int i = 7; i >= 0; i--) get_bit(v[i]);
      put_bit(nack);
   endtask : get_byte
   // start also serves as repeated start from a low clock
   task automatic bus_start();
      sda_m = 1'b1;
      half();
      scl_m = 1'b1;
      half();
      sda_m = 1'b0;
      half();
      scl_m = 1'b0;
   endtask : bus_start
   task automatic bus_stop();
      sda_m = 1'b0;
      half();
      scl_m = 1'b1;
      half();
      sda_m = 1'b1;
      half();
   endtask : bus_stop
   task automatic reg_wr(input logic [2:0] p, input logic [15:0] v, input int n);
      bus_start();
      put_byte({DEV_ADDR_RST, 1'b0});
      put_byte({5'h00, p});
      if (n == 2) put_byte(v[15:8]);
      put_byte(v[7:0]);
      bus_stop();
   endtask : reg_wr
   task automatic reg_rd(input logic [2:0] p, input int n, output logic [15:0] v);
      v = 16'h0000;
      bus_start();
      put_byte({DEV_ADDR_RST, 1'b0});
      put_byte({5'h00, p});
      bus_start();
      put_byte({DEV_ADDR_RST, 1'b1});
      if (n == 2) get_byte(v[15:8], 1'b0);
      get_byte(v[7:0], 1'b1);
      bus_stop();
   endtask : reg_rd
   // set the input, let two conversions land, read the status flags
   task automatic step(input logic [11:0] v, input logic [15:0] st);
      value = v;
      c0 = conv_count;
      for (int i = 0; i < 4000 && conv_count < c0 + 2; i++) @(negedge core_clk);
      check("landed", 16'(conv_count - c0 >= 2), 16'h0001);
      half();
      reg_rd(PTR_STATUS, 1, d);
      check("status", d, st);
   endtask : step
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run

   initial begin
      #450000;
      fail_count++;
      complete_run();
   end

   initial begin
      repeat (4) @(negedge conv_clk);
      @(negedge core_clk);
      rst_n = 1'b1;
      repeat (8) @(negedge core_clk);
      reg_rd(PTR_SETUP, 1, d);
      check("setup", d, 16'h0000);
      reg_rd(PTR_UNDER, 2, d);
      check("under", d, 16'h0000);
      reg_rd(PTR_OVER, 2, d);
      check("over", d, 16'h0fff);
      check("alert_oe_n", 16'(alert_oe_n), 16'h0001);
      reg_wr(PTR_SETUP, 16'h0002, 1);
      reg_rd(PTR_SETUP, 1, d);
      check("setup", d, 16'h0000);
      reg_wr(PTR_UNDER, 16'hf123, 2);
      reg_rd(PTR_UNDER, 2, d);
      check("under", d, 16'h0123);
      reg_wr(PTR_OVER, 16'hfabc, 2);
      reg_rd(PTR_OVER, 2, d);
      check("over", d, 16'h0abc);
      reg_rd(3'h6, 2, d);
      check("unmapped", d, 16'h0000);
      check("conversions", 16'(conv_count), 16'h0000);
      $display("test registers done");
      for (int c = 1; c <= 7; c++) begin
         reg_wr(PTR_SETUP, 16'(c << CYC_LO), 1);
         repeat (2) @(posedge conv_start);
         t0 = $realtime;
         @(posedge conv_start);
         ex = P_CONV * (32 << (c - 1)) * CLK_PERIOD_NS;
         check("interval", 16'(($realtime - t0 - ex) ** 2 < 10000.0), 16'h0001);
      end
      reg_wr(PTR_SETUP, 16'h0000, 1);
      half();
      c0 = conv_count;
      repeat (4000) @(negedge core_clk);
      check("stopped", 16'(conv_count - c0), 16'h0000);
      $display("test interval done");
      reg_wr(PTR_OVER, 16'h0800, 2);
      reg_wr(PTR_UNDER, 16'h0100, 2);
      reg_wr(PTR_HYST, 16'h0010, 2);
      reg_wr(PTR_SETUP, 16'h002d, 1);
      step(12'h900, 16'h0002);
      check("alert", 16'(alert), 16'h0001);
      check("alert_oe_n", 16'(alert_oe_n), 16'h0000);
      reg_rd(PTR_RESULT, 2, d);
      check("result", d, 16'h8900);
      step(12'h7f8, 16'h0002);
      step(12'h7e0, 16'h0000);
      check("alert", 16'(alert), 16'h0000);
      step(12'h080, 16'h0001);
      step(12'h120, 16'h0000);
      $display("test alert done");
      reg_wr(PTR_SETUP, 16'h003d, 1);
      step(12'h900, 16'h0002);
      step(12'h400, 16'h0002);
      reg_wr(PTR_STATUS, 16'h0002, 1);
      reg_rd(PTR_STATUS, 1, d);
      check("status", d, 16'h0000);
      step(12'h080, 16'h0001);
      step(12'h400, 16'h0001);
      reg_wr(PTR_STATUS, 16'h0001, 1);
      reg_rd(PTR_STATUS, 1, d);
      check("status", d, 16'h0000);
      reg_wr(PTR_SETUP, 16'h002c, 1);
      step(12'h900, 16'h0002);
      check("alert", 16'(alert), 16'h0000);
      reg_wr(PTR_SETUP, 16'h0024, 1);
      reg_rd(PTR_RESULT, 2, d);
      check("result", d, 16'h0900);
      reg_wr(PTR_SETUP, 16'h0020, 1);
      half();
      check("alert_oe_n", 16'(alert_oe_n), 16'h0001);
      $display("test hold and pin done");
      complete_run();
   end
endmodule : aacl_top_bench
